// File: hw/lfvs_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - auto select: 0 normal, 1 auto detect
// - first stable vibration stores frequency one, second ends auto
// - auto off: settings never change themselves
// - threshold 1..8000, reset 500, gates detection
// - frequency one 10..1000, idle while gain zero
// - frequency two 10..1000, idle while gain zero
// - gains 0..9, reset 0, both zero disables
// - suppression only in position control modes
// - auto end on no vibration, both gains zero: none found
// - auto select sixteen bits at 013a, 0..1
// - search disables filter, stores group one, then group two only on a second find
module lfvs_ctrl
    import lfvs_pkg::*;
(
    input  wire logic        i_clk,           // 100 MHz clock
    input  wire logic        i_reset_n,       // sync reset, low
    input  wire logic [15:0] s_axi_awaddr,    // write address
    input  wire logic        s_axi_awvalid,   // write address valid
    output logic             s_axi_awready,   // write address ready
    input  wire logic [31:0] s_axi_wdata,     // write data
    input  wire logic [3:0]  s_axi_wstrb,     // write strobes
    input  wire logic        s_axi_wvalid,    // write data valid
    output logic             s_axi_wready,    // write data ready
    output logic [1:0]       s_axi_bresp,     // write response
    output logic             s_axi_bvalid,    // write response valid
    input  wire logic        s_axi_bready,    // write response ready
    input  wire logic [15:0] s_axi_araddr,    // read address
    input  wire logic        s_axi_arvalid,   // read address valid
    output logic             s_axi_arready,   // read address ready
    output logic [31:0]      s_axi_rdata,     // read data
    output logic [1:0]       s_axi_rresp,     // read response
    output logic             s_axi_rvalid,    // read data valid
    input  wire logic        s_axi_rready,    // read data ready
    input  wire logic        i_vib_found,     // detector: freq stable
    input  wire logic        i_vib_absent,    // detector: no vibration
    input  wire logic [15:0] i_vib_freq,      // detector: measured Hz
    output logic             o_filter_on,     // suppression filter run
    output logic             o_search_on,     // detector search run
    output logic [15:0]      o_freq_one,      // first frequency
    output logic [15:0]      o_gain_one,      // first gain
    output logic [15:0]      o_freq_two,      // second frequency
    output logic [15:0]      o_gain_two,      // second gain
    output logic [15:0]      o_threshold      // detection level
);

    // ==========================================================
    // registers
    logic [15:0]   freq_one_q;
    logic [15:0]   gain_one_q;
    logic [15:0]   freq_two_q;
    logic [15:0]   gain_two_q;
    logic [15:0]   auto_sel_q;
    logic [15:0]   threshold_q;
    logic [1:0]    mode_q;
    logic          none_found_q;
    search_state_t state_q;

    // ==========================================================
    // write channel
    logic [15:0] aw_addr_q;
    logic        aw_have_q;
    logic [15:0] w_data_q;
    logic [1:0]  w_strb_q;
    logic        w_have_q;
    logic        wr_fire;
    logic        wr_mapped;
    logic        wr_legal;
    logic [15:0] wr_value;

    assign wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_value = { w_strb_q[1] ? w_data_q[15:8] : 8'h00,
                        w_strb_q[0] ? w_data_q[7:0]  : 8'h00 };

    lfvs_range_check u_check (
        .i_addr   (aw_addr_q),
        .i_data   (wr_value),
        .o_mapped (wr_mapped),
        .o_legal  (wr_legal)
    );

    logic wr_ok;
    logic sw_cfg_wr;
    assign wr_ok = wr_fire && wr_mapped && wr_legal
                   && (w_strb_q == 2'b11);
    // while searching only the auto select and the mode can be written
    assign sw_cfg_wr = wr_ok && (state_q == SEARCH_IDLE);

    logic sw_abort;
    // a zero written to the auto select ends a running search at once
    assign sw_abort = wr_ok && aw_addr_q == ADDR_AUTO_SEL
                      && wr_value != AUTO_SEL_MAX;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            aw_have_q     <= 1'b0;
            aw_addr_q     <= 16'h0000;
            s_axi_awready <= 1'b0;
        end
        else if (wr_fire)
        begin
            aw_have_q     <= 1'b0;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_q     <= 1'b1;
            aw_addr_q     <= {2'b00, s_axi_awaddr[15:2]};
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_have_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            w_have_q     <= 1'b0;
            w_data_q     <= 16'h0000;
            w_strb_q     <= 2'b00;
            s_axi_wready <= 1'b0;
        end
        else if (wr_fire)
        begin
            w_have_q     <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_q     <= 1'b1;
            w_data_q     <= s_axi_wdata[15:0];
            w_strb_q     <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= !w_have_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // auto detection sequencer
    logic det_done;
    assign det_done = i_vib_found || i_vib_absent;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            state_q <= SEARCH_IDLE;
        else if (sw_abort)
            state_q <= SEARCH_IDLE;
        else
        begin
            unique case (state_q)
                SEARCH_IDLE:
                    if (wr_ok && aw_addr_q == ADDR_AUTO_SEL
                        && wr_value == AUTO_SEL_MAX)
                        state_q <= SEARCH_FIRST;
                SEARCH_FIRST:
                    if (i_vib_found)
                        state_q <= SEARCH_SECOND;
                    else if (i_vib_absent)
                        state_q <= SEARCH_IDLE;
                SEARCH_SECOND:
                    if (det_done)
                        state_q <= SEARCH_IDLE;
                default:
                    state_q <= SEARCH_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            auto_sel_q <= RST_AUTO_SEL;
        else if (state_q != SEARCH_IDLE && det_done
                 && (state_q == SEARCH_SECOND || i_vib_absent))
            auto_sel_q <= 16'h0000;
        else if (wr_ok && aw_addr_q == ADDR_AUTO_SEL)
            auto_sel_q <= wr_value;
    end

    // frequency and gain groups: hardware only touches them in auto
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            freq_one_q <= RST_FREQ;
            gain_one_q <= RST_GAIN;
        end
        else if (state_q == SEARCH_FIRST && i_vib_found)
        begin
            freq_one_q <= i_vib_freq;
            gain_one_q <= GAIN_FOUND;
        end
        else if (sw_cfg_wr && aw_addr_q == ADDR_FREQ_ONE)
            freq_one_q <= wr_value;
        else if (sw_cfg_wr && aw_addr_q == ADDR_GAIN_ONE)
            gain_one_q <= wr_value;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            freq_two_q <= RST_FREQ;
            gain_two_q <= RST_GAIN;
        end
        else if (state_q == SEARCH_SECOND && i_vib_found)
        begin
            freq_two_q <= i_vib_freq;
            gain_two_q <= GAIN_FOUND;
        end
        else if (sw_cfg_wr && aw_addr_q == ADDR_FREQ_TWO)
            freq_two_q <= wr_value;
        else if (sw_cfg_wr && aw_addr_q == ADDR_GAIN_TWO)
            gain_two_q <= wr_value;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            threshold_q <= RST_THRESHOLD;
        else if (sw_cfg_wr && aw_addr_q == ADDR_THRESHOLD)
            threshold_q <= wr_value;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            mode_q <= MODE_PULSE_POS;
        else if (wr_ok && aw_addr_q == ADDR_MODE)
            mode_q <= wr_value[1:0];
    end

    // sticky result: set when a search ends on no vibration with both gains zero
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            none_found_q <= 1'b0;
        else if (state_q == SEARCH_FIRST && i_vib_absent)
            none_found_q <= (gain_one_q == RST_GAIN)
                            && (gain_two_q == RST_GAIN);
        else if (state_q == SEARCH_FIRST)
            none_found_q <= 1'b0;
    end

    // ==========================================================
    // filter enable
    logic pos_mode;
    assign pos_mode = (mode_q != MODE_OTHER);

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            o_filter_on <= 1'b0;
            o_search_on <= 1'b0;
        end
        else
        begin
            o_filter_on <= pos_mode && state_q == SEARCH_IDLE
                           && (gain_one_q != 16'h0000
                               || gain_two_q != 16'h0000);
            o_search_on <= pos_mode && state_q != SEARCH_IDLE;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            o_freq_one  <= RST_FREQ;
            o_gain_one  <= RST_GAIN;
            o_freq_two  <= RST_FREQ;
            o_gain_two  <= RST_GAIN;
            o_threshold <= RST_THRESHOLD;
        end
        else
        begin
            o_freq_one  <= freq_one_q;
            o_gain_one  <= gain_one_q;
            o_freq_two  <= freq_two_q;
            o_gain_two  <= gain_two_q;
            o_threshold <= threshold_q;
        end
    end

    // ==========================================================
    // read channel
    logic [15:0] rd_value;
    logic        rd_mapped;

    always_comb
    begin
        rd_mapped = 1'b1;
        rd_value  = 16'h0000;
        unique case ({2'b00, s_axi_araddr[15:2]})
            ADDR_FREQ_ONE:  rd_value = freq_one_q;
            ADDR_GAIN_ONE:  rd_value = gain_one_q;
            ADDR_FREQ_TWO:  rd_value = freq_two_q;
            ADDR_GAIN_TWO:  rd_value = gain_two_q;
            ADDR_AUTO_SEL:  rd_value = auto_sel_q;
            ADDR_THRESHOLD: rd_value = threshold_q;
            ADDR_MODE:      rd_value = {14'h0000, mode_q};
            ADDR_STATUS:
            begin
                rd_value[STAT_ACTIVE_BIT] = o_filter_on;
                rd_value[STAT_SEARCH_BIT] = state_q != SEARCH_IDLE;
                rd_value[STAT_NONE_BIT]   = none_found_q;
            end
            default:        rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {16'h0000, rd_value};
            s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // ==========================================================
    // checks
    default clocking cb_chk @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    AST_AUTO_LEGAL: assert property (
        auto_sel_q <= AUTO_SEL_MAX)
        else $error("auto select out of range");
    AST_FOUND_STORE: assert property (
        state_q == SEARCH_FIRST && i_vib_found
        |=> freq_one_q == $past(i_vib_freq) && gain_one_q == GAIN_FOUND)
        else $error("first frequency not stored");
    AST_MANUAL_HOLD: assert property (
        auto_sel_q == RST_AUTO_SEL && !wr_fire
        |=> $stable(freq_one_q) && $stable(gain_one_q)
        && $stable(freq_two_q) && $stable(gain_two_q))
        else $error("settings changed without a write");
    AST_THRESH_RANGE: assert property (
        threshold_q >= THRESH_MIN && threshold_q <= THRESH_MAX)
        else $error("threshold out of range");
    AST_GAIN_RANGE: assert property (
        gain_one_q <= GAIN_MAX && gain_two_q <= GAIN_MAX)
        else $error("gain out of range");
    AST_FREQ_RANGE: assert property (
        wr_fire && state_q == SEARCH_IDLE && aw_addr_q == ADDR_FREQ_TWO
        && (wr_value < FREQ_MIN || wr_value > FREQ_MAX)
        |=> $stable(freq_two_q))
        else $error("illegal frequency two write accepted");
    AST_POS_ONLY: assert property (
        mode_q == MODE_OTHER |=> !o_filter_on)
        else $error("filter on outside position mode");
    AST_SEARCH_OFF: assert property (
        state_q != SEARCH_IDLE |=> !o_filter_on)
        else $error("filter on while searching");
    AST_SEARCH_END: assert property (
        state_q == SEARCH_SECOND && det_done
        |=> auto_sel_q == 16'h0000 && state_q == SEARCH_IDLE)
        else $error("auto select not cleared");
    AST_REJECT: assert property (
        wr_fire && !wr_legal && aw_addr_q == ADDR_GAIN_ONE
        |=> $stable(gain_one_q))
        else $error("illegal write accepted");

    COV_SEARCH_BOTH: cover property (state_q == SEARCH_SECOND && i_vib_found);
    COV_SEARCH_NONE: cover property (state_q == SEARCH_FIRST && i_vib_absent);
    COV_REJECT: cover property (wr_fire && wr_mapped && !wr_legal);
    COV_ABORT: cover property (sw_abort && state_q != SEARCH_IDLE);

endmodule // lfvs_ctrl

// File: hw/lfvs_pkg.sv
package lfvs_pkg;

    // ==========================================================
    // register indexes: the bus byte address is four times these
    localparam logic [15:0] ADDR_FREQ_ONE   = 16'h0132;
    localparam logic [15:0] ADDR_GAIN_ONE   = 16'h0134;
    localparam logic [15:0] ADDR_FREQ_TWO   = 16'h0136;
    localparam logic [15:0] ADDR_GAIN_TWO   = 16'h0138;
    localparam logic [15:0] ADDR_AUTO_SEL   = 16'h013a;
    localparam logic [15:0] ADDR_THRESHOLD  = 16'h013c;
    localparam logic [15:0] ADDR_MODE       = 16'h0140;
    localparam logic [15:0] ADDR_STATUS     = 16'h0144;

    // ==========================================================
    // reset values
    localparam logic [15:0] RST_FREQ        = 16'h03e8;
    localparam logic [15:0] RST_GAIN        = 16'h0000;
    localparam logic [15:0] RST_AUTO_SEL    = 16'h0000;
    localparam logic [15:0] RST_THRESHOLD   = 16'h01f4;

    // ==========================================================
    // legal ranges
    localparam logic [15:0] FREQ_MIN        = 16'h000a;
    localparam logic [15:0] FREQ_MAX        = 16'h03e8;
    localparam logic [15:0] GAIN_MAX        = 16'h0009;
    localparam logic [15:0] AUTO_SEL_MAX    = 16'h0001;
    localparam logic [15:0] THRESH_MIN      = 16'h0001;
    localparam logic [15:0] THRESH_MAX      = 16'h1f40;
    localparam logic [15:0] GAIN_FOUND      = 16'h0001;

    // ==========================================================
    // status field positions
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_SEARCH_BIT = 1;
    localparam int STAT_NONE_BIT   = 2;

    // ==========================================================
    // control modes: three position loop modes and one other mode
    localparam logic [1:0] MODE_PULSE_POS    = 2'h0;
    localparam logic [1:0] MODE_REGISTER_POS = 2'h1;
    localparam logic [1:0] MODE_COMBINED_POS = 2'h2;
    localparam logic [1:0] MODE_OTHER        = 2'h3;

    // ==========================================================
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SEARCH_IDLE,
        SEARCH_FIRST,
        SEARCH_SECOND
    } search_state_t;

endpackage

// File: hw/lfvs_range_check.sv
`timescale 1ns/10ps
// ==========================================================
// range checker for written parameter values
module lfvs_range_check
    import lfvs_pkg::*;
(
    input  wire logic [15:0] i_addr,    // register index
    input  wire logic [15:0] i_data,    // value to be written
    output logic             o_mapped,  // address is a register
    output logic             o_legal    // value inside its range
);

    function automatic logic in_range(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    always_comb
    begin
        o_mapped = 1'b1;
        o_legal  = 1'b0;
        unique case (i_addr)
            ADDR_FREQ_ONE,
            ADDR_FREQ_TWO:  o_legal = in_range(i_data, FREQ_MIN, FREQ_MAX);
            ADDR_GAIN_ONE,
            ADDR_GAIN_TWO:  o_legal = in_range(i_data, 16'h0000, GAIN_MAX);
            ADDR_AUTO_SEL:  o_legal = in_range(i_data, 16'h0000,
                                               AUTO_SEL_MAX);
            ADDR_THRESHOLD: o_legal = in_range(i_data, THRESH_MIN,
                                               THRESH_MAX);
            ADDR_MODE:      o_legal = 1'b1;
            ADDR_STATUS:    o_legal = 1'b0;
            default:        o_mapped = 1'b0;
        endcase
    end

endmodule // lfvs_range_check

// File: verif/tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// self-checking bench for the vibration suppression controls
module tb_top
    import lfvs_pkg::*;
;
    logic        i_clk;
    logic        i_reset_n;
    logic [15:0] s_axi_awaddr, s_axi_araddr, i_vib_freq;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, i_vib_found, i_vib_absent;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, o_filter_on, o_search_on;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] o_freq_one, o_gain_one, o_freq_two, o_gain_two;
    logic [15:0] o_threshold;
    logic [1:0]  resp;
    logic [31:0] data;
    int          failures;
    int          comparisons;

    lfvs_ctrl i_dut (
        .i_clk, .i_reset_n,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .i_vib_found, .i_vib_absent, .i_vib_freq,
        .o_filter_on, .o_search_on,
        .o_freq_one, .o_gain_one, .o_freq_two, .o_gain_two,
        .o_threshold
    );

    // ==========================================================
    // helpers
    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input logic [3:0] s);
        @(posedge i_clk);
        s_axi_awaddr  <= {a[13:0], 2'b00};
        s_axi_wdata   <= {16'h0000, d};
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge i_clk);
        s_axi_araddr  <= {a[13:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
        rd(a);
        chk(data, {16'h0000, e});
    endtask

    // one-cycle detector pulse: found when f is high, absent otherwise
    task automatic pulse(input logic f, input logic [15:0] hz);
        @(posedge i_clk);
        i_vib_found  <= f;
        i_vib_absent <= !f;
        i_vib_freq   <= hz;
        @(posedge i_clk);
        i_vib_found  <= 1'b0;
        i_vib_absent <= 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rdchk(ADDR_FREQ_ONE, RST_FREQ);
        rdchk(ADDR_FREQ_TWO, RST_FREQ);
        rdchk(ADDR_GAIN_ONE, RST_GAIN);
        rdchk(ADDR_GAIN_TWO, RST_GAIN);
        rdchk(ADDR_AUTO_SEL, RST_AUTO_SEL);
        rdchk(ADDR_THRESHOLD, RST_THRESHOLD);
        chk({16'h0000, o_threshold}, {16'h0000, RST_THRESHOLD});
    endtask

    task automatic t_range();
        logic [15:0] ad [12] = '{ADDR_FREQ_ONE, ADDR_FREQ_ONE, ADDR_GAIN_ONE,
            ADDR_FREQ_TWO, ADDR_GAIN_TWO, ADDR_AUTO_SEL, ADDR_THRESHOLD,
            ADDR_THRESHOLD, ADDR_FREQ_ONE, ADDR_GAIN_ONE, ADDR_GAIN_ONE,
            ADDR_THRESHOLD};
        logic [15:0] wv [12] = '{16'h0009, 16'h03e9, 16'h000a, 16'h0009,
            16'h000a, 16'h0002, 16'h0000, 16'h1f41, 16'h000a, 16'h0009,
            16'h0000, 16'h1f40};
        logic [15:0] ev [12] = '{16'h03e8, 16'h03e8, 16'h0000, 16'h03e8,
            16'h0000, 16'h0000, 16'h01f4, 16'h01f4, 16'h000a, 16'h0009,
            16'h0000, 16'h1f40};
        for (int i = 0; i < 12; i++)
        begin
            wr(ad[i], wv[i], 4'hf);
            rdchk(ad[i], ev[i]);
        end
        wr(ADDR_THRESHOLD, 16'h0001, 4'hf);
        rdchk(ADDR_THRESHOLD, 16'h0001);
        wr(ADDR_THRESHOLD, 16'h0064, 4'h1);
        rdchk(ADDR_THRESHOLD, 16'h0001);
    endtask

    task automatic t_unmapped();
        wr(16'h0130, 16'h0001, 4'hf);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        rd(16'h0130);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        chk(data, 32'h0000_0000);
    endtask

    task automatic t_manual();
        wr(ADDR_FREQ_ONE, 16'h0064, 4'hf);
        wr(ADDR_AUTO_SEL, 16'h0001, 4'hf);
        wr(ADDR_AUTO_SEL, 16'h0000, 4'hf);
        pulse(1'b1, 16'h0055);
        pulse(1'b0, 16'h0055);
        rdchk(ADDR_FREQ_ONE, 16'h0064);
        rdchk(ADDR_GAIN_ONE, 16'h0000);
        rdchk(ADDR_STATUS, 16'h0000);
    endtask

    task automatic t_auto();
        wr(ADDR_AUTO_SEL, 16'h0001, 4'hf);
        rdchk(ADDR_AUTO_SEL, 16'h0001);
        rdchk(ADDR_STATUS, 16'h0002);
        chk({31'h0, o_search_on}, 32'h0000_0001);
        pulse(1'b1, 16'h0020);
        rdchk(ADDR_FREQ_ONE, 16'h0020);
        rdchk(ADDR_GAIN_ONE, GAIN_FOUND);
        rdchk(ADDR_STATUS, 16'h0002);
        pulse(1'b1, 16'h0030);
        rdchk(ADDR_FREQ_TWO, 16'h0030);
        rdchk(ADDR_GAIN_TWO, GAIN_FOUND);
        rdchk(ADDR_AUTO_SEL, 16'h0000);
        rdchk(ADDR_STATUS, 16'h0001);
        chk({16'h0000, o_freq_two}, 32'h0000_0030);
        chk({16'h0000, o_freq_one}, 32'h0000_0020);
        chk({16'h0000, o_gain_one}, {16'h0000, GAIN_FOUND});
        chk({16'h0000, o_gain_two}, {16'h0000, GAIN_FOUND});
        chk({31'h0, o_search_on}, 32'h0000_0000);
        chk({31'h0, o_filter_on}, 32'h0000_0001);
    endtask

    task automatic t_mode();
        wr(ADDR_GAIN_ONE, 16'h0001, 4'hf);
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_MODE, 16'(m), 4'hf);
            rdchk(ADDR_STATUS, (m == 3) ? 16'h0000 : 16'h0001);
            chk({31'h0, o_filter_on}, (m == 3) ? 32'h0 : 32'h1);
        end
        wr(ADDR_MODE, 16'h0000, 4'hf);
    endtask

    task automatic t_none();
        wr(ADDR_GAIN_ONE, 16'h0000, 4'hf);
        wr(ADDR_GAIN_TWO, 16'h0000, 4'hf);
        rdchk(ADDR_STATUS, 16'h0000);
        wr(ADDR_AUTO_SEL, 16'h0001, 4'hf);
        pulse(1'b0, 16'h0000);
        rdchk(ADDR_AUTO_SEL, 16'h0000);
        rdchk(ADDR_GAIN_ONE, 16'h0000);
        rdchk(ADDR_STATUS, 16'h0004);
    endtask

    // ==========================================================
    // clock, watchdog and main sequence
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        failures++;
        summarize();
    end

    initial
    begin
        failures      = 0;
        comparisons   = 0;
        i_reset_n     = 1'b0;
        s_axi_awaddr  = 16'h0000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0000_0000;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 16'h0000;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        i_vib_found   = 1'b0;
        i_vib_absent  = 1'b0;
        i_vib_freq    = 16'h0000;
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_reset();
        t_range();
        t_unmapped();
        t_manual();
        t_auto();
        t_mode();
        t_none();
        summarize();
    end
endmodule // tb_top
